// *** src/arpr_pkg.sv ***
package arpr_pkg;

    // Control port addresses
    localparam logic [6:0] ARPR_ADDR_RX_AIF = 7'h1C;
    localparam logic [6:0] ARPR_ADDR_READBACK = 7'h1D;
    localparam logic [6:0] ARPR_ADDR_POWER = 7'h1E;

    // Field positions
    localparam int ARPR_AIF_FMT_LSB = 0;
    localparam int ARPR_AIF_WL_LSB = 2;
    localparam int ARPR_AIF_BCP_BIT = 4;
    localparam int ARPR_AIF_LRP_BIT = 5;
    localparam int ARPR_AIF_MASTER_BIT = 6;
    localparam int ARPR_AIF_HOLD_BIT = 7;
    localparam int ARPR_RB_SEL_LSB = 0;
    localparam int ARPR_RB_CONTINUOUS_BIT = 3;
    localparam int ARPR_RB_FLAG_BIT = 4;
    localparam int ARPR_RB_MASK_BIT = 6;
    localparam int ARPR_RB_HIGH_BIT = 7;
    localparam int ARPR_PD_PLL_BIT = 0;
    localparam int ARPR_PD_RX_BIT = 1;
    localparam int ARPR_PD_TX_BIT = 2;

    // Reset values
    localparam logic [7:0] ARPR_RX_AIF_RESET = 8'h06;
    localparam logic [7:0] ARPR_READBACK_RESET = 8'h80;
    localparam logic [7:0] ARPR_POWER_RESET = 8'h07;
    // Writable bits; the rest read as zero
    localparam logic [7:0] ARPR_READBACK_WMASK = 8'hDF;
    localparam logic [7:0] ARPR_POWER_WMASK = 8'h07;

    // Readback select codes
    localparam logic [2:0] ARPR_SEL_INT = 3'h0;
    localparam logic [2:0] ARPR_SEL_CS1 = 3'h1;
    localparam logic [2:0] ARPR_SEL_CS5 = 3'h5;
    localparam logic [2:0] ARPR_SEL_SPDIF = 3'h6;

    // Audio word widths
    localparam int ARPR_WORD_W = 24;
    localparam int ARPR_FLAG_W = 4;
    localparam int ARPR_CS_REGS = 5;

    // Master clock timing: clk cycles per bit clock half period,
    // bit clocks per frame clock half period
    localparam int ARPR_BCLK_HALF_CYCLES = 4;
    localparam int ARPR_BCLKS_PER_HALF_FRAME = 32;

    typedef enum logic [1:0] {
        ARPR_FMT_RIGHT = 2'h0,
        ARPR_FMT_LEFT = 2'h1,
        ARPR_FMT_I2S = 2'h2,
        ARPR_FMT_DSP = 2'h3
    } arpr_format_type;

    typedef struct packed {
        logic clocks_hold_enable;
        logic interface_master_select;
        logic rx_frame_polarity_dsp_variant;
        logic bclk_invert;
        logic [1:0] rx_word_length;
        arpr_format_type rx_interface_format;
    } arpr_aif_type;

    typedef struct packed {
        logic rx_high_rate_enable;
        logic rx_truncation_mask;
        logic reserved;
        logic flag_append_enable;
        logic continuous_readback_enable;
        logic [2:0] readback_register_select;
    } arpr_readback_type;

    typedef struct packed {
        logic [4:0] reserved;
        logic transmitter_power_down;
        logic receiver_power_down;
        logic pll_power_down;
    } arpr_power_type;

    typedef struct packed {
        logic [7:0] int_status;
        logic [ARPR_CS_REGS-1:0][7:0] chan_status;
        logic [7:0] spdif_status;
    } arpr_status_type;

    typedef enum logic [1:0] {
        ARPR_CG_STOPPED = 2'b01,
        ARPR_CG_RUNNING = 2'b10
    } arpr_cg_state_type;

endpackage : arpr_pkg

// *** src/arpr_clock_gen.sv ***
`timescale 1ns/1ps
module arpr_clock_gen
    import arpr_pkg::*;
#(
    parameter int HALF_CYCLES = ARPR_BCLK_HALF_CYCLES,
    parameter int BCLKS_PER_HALF = ARPR_BCLKS_PER_HALF_FRAME
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic bclk_invert,
    input wire logic frame_invert,
    output logic bclk_o,
    output logic lrclk_o,
    output logic clocks_oe
);

    arpr_cg_state_type state_reg;
    logic [7:0] div_reg;
    logic [7:0] bit_reg;
    logic bclk_reg;
    logic lrclk_reg;
    logic wrap;
    logic fall;

    assign wrap = (div_reg == 8'(HALF_CYCLES - 1));
    assign fall = wrap && bclk_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ARPR_CG_STOPPED;
        end else begin
            unique case (state_reg)
                ARPR_CG_STOPPED: if (run) state_reg <= ARPR_CG_RUNNING;
                ARPR_CG_RUNNING: if (!run) state_reg <= ARPR_CG_STOPPED;
                default: state_reg <= ARPR_CG_STOPPED;
            endcase
        end
    end

    // Restart from a frame boundary so the partner sees whole frames
    always_ff @(posedge clk) begin
        if (rst || state_reg != ARPR_CG_RUNNING) begin
            div_reg <= 8'h00;
            bit_reg <= 8'h00;
            bclk_reg <= 1'b0;
            lrclk_reg <= 1'b0;
        end else begin
            div_reg <= wrap ? 8'h00 : div_reg + 8'h01;
            if (wrap) bclk_reg <= ~bclk_reg;
            if (fall) begin
                if (bit_reg == 8'(BCLKS_PER_HALF - 1)) begin
                    bit_reg <= 8'h00;
                    lrclk_reg <= ~lrclk_reg;
                end else begin
                    bit_reg <= bit_reg + 8'h01;
                end
            end
        end
    end

    // Polarity applied in the output flop to keep pins glitch free
    always_ff @(posedge clk) begin
        if (rst) begin
            bclk_o <= 1'b0;
            lrclk_o <= 1'b0;
            clocks_oe <= 1'b0;
        end else begin
            bclk_o <= bclk_reg ^ bclk_invert;
            lrclk_o <= lrclk_reg ^ frame_invert;
            clocks_oe <= (state_reg == ARPR_CG_RUNNING);
        end
    end

endmodule : arpr_clock_gen

// *** src/arpr_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - Polarity bit 5 inverts frame clock, or picks DSP mode B in DSP.
// - Master select 0: bit and frame clocks are inputs from partner.
// - Master select 1: device drives bit and frame clocks while S/PDIF is locked with receiver powered, or bit 7 set.
// - Master only: bit 7 keeps clocks running after S/PDIF loss.
// - Select field picks readback status: interrupt, channel 1-5, S/PDIF.
// - Bit 3 enables continuous readback; reset disabled.
// - Bit 4 appends status flags to audio data; reset disabled.
// - Mask bit 6 clear truncates words to channel status length.
// - Bit 7 allows 192kHz receive, else 96kHz max; reset enabled.
// - Power bits 0,1,2 disable PLL, receiver, transmitter; reset to 1.
// - Format field: 00 right, 01 left, 10 I2S, 11 DSP.
// - Clearing transmitter power-down enables the transmitter.
module arpr_regs
    import arpr_pkg::*;
#(
    parameter int HALF_CYCLES = ARPR_BCLK_HALF_CYCLES,
    parameter int BCLKS_PER_HALF = ARPR_BCLKS_PER_HALF_FRAME
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire arpr_status_type status_in,
    output logic [7:0] status_readback,
    output logic status_readback_valid,
    input wire logic spdif_lock_pin,
    input wire logic bclk_i,
    input wire logic lrclk_i,
    output logic bclk_o,
    output logic bclk_oe,
    output logic lrclk_o,
    output logic lrclk_oe,
    output logic slave_frame_clk,
    output logic slave_bit_clk,
    output logic dsp_mode_b,
    output arpr_format_type rx_format,
    input wire logic [ARPR_WORD_W-1:0] rx_word,
    input wire logic [4:0] rx_word_bits,
    input wire logic [ARPR_FLAG_W-1:0] rx_flags,
    input wire logic rx_word_valid,
    output logic [ARPR_FLAG_W+ARPR_WORD_W-1:0] rx_out_word,
    output logic rx_out_valid,
    output logic rx_high_rate_enable,
    output logic pll_power_down,
    output logic receiver_power_down,
    output logic transmitter_power_down
);

    arpr_aif_type aif_reg;
    arpr_readback_type rb_reg;
    arpr_power_type pwr_reg;

    // Control writes
    always_ff @(posedge clk) begin
        if (rst) begin
            aif_reg <= arpr_aif_type'(ARPR_RX_AIF_RESET);
            rb_reg <= arpr_readback_type'(ARPR_READBACK_RESET);
            pwr_reg <= arpr_power_type'(ARPR_POWER_RESET);
        end else if (reg_write) begin
            unique case (reg_addr)
                ARPR_ADDR_RX_AIF: aif_reg <= arpr_aif_type'(reg_wdata);
                ARPR_ADDR_READBACK:
                    rb_reg <= arpr_readback_type'(reg_wdata
                        & ARPR_READBACK_WMASK);
                ARPR_ADDR_POWER:
                    pwr_reg <= arpr_power_type'(reg_wdata
                        & ARPR_POWER_WMASK);
                default: ;
            endcase
        end
    end

    // Control reads; unmapped addresses answer zero
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_read;
            if (reg_read) begin
                unique case (reg_addr)
                    ARPR_ADDR_RX_AIF: reg_rdata <= aif_reg;
                    ARPR_ADDR_READBACK: reg_rdata <= rb_reg;
                    ARPR_ADDR_POWER: reg_rdata <= pwr_reg;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Status readback mux
    logic [7:0] status_sel;
    always_comb begin
        status_sel = 8'h00;
        if (rb_reg.readback_register_select == ARPR_SEL_INT) begin
            status_sel = status_in.int_status;
        end else if (rb_reg.readback_register_select <= ARPR_SEL_CS5) begin
            status_sel = status_in.chan_status[
                rb_reg.readback_register_select - ARPR_SEL_CS1];
        end else if (rb_reg.readback_register_select == ARPR_SEL_SPDIF) begin
            status_sel = status_in.spdif_status;
        end
    end

    // Continuous mode refreshes every cycle, otherwise only on a read
    always_ff @(posedge clk) begin
        if (rst) begin
            status_readback <= 8'h00;
            status_readback_valid <= 1'b0;
        end else begin
            status_readback_valid <= reg_read
                || rb_reg.continuous_readback_enable;
            if (reg_read || rb_reg.continuous_readback_enable) begin
                status_readback <= status_sel;
            end
        end
    end

    // Pin synchronisers: lock, bit clock, frame clock
    logic [2:0] pin_raw;
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [2:0] pin_s3_reg;
    logic [2:0] pin_stable_reg;
    assign pin_raw = {lrclk_i, bclk_i, spdif_lock_pin};

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
            pin_s3_reg <= 3'h0;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            always_ff @(posedge clk) begin
                if (rst) begin
                    pin_stable_reg[g] <= 1'b0;
                end else if (pin_s2_reg[g] == pin_s3_reg[g]) begin
                    pin_stable_reg[g] <= pin_s3_reg[g];
                end
            end
        end
    endgenerate

    logic source_present;
    logic frame_invert;
    logic clk_run;
    logic gen_bclk;
    logic gen_lrclk;
    logic gen_oe;

    // Receiver powered down counts as no source
    assign source_present = pin_stable_reg[0] && !pwr_reg.receiver_power_down;
    assign frame_invert = aif_reg.rx_frame_polarity_dsp_variant
        && (aif_reg.rx_interface_format != ARPR_FMT_DSP);
    assign clk_run = aif_reg.interface_master_select
        && (source_present || aif_reg.clocks_hold_enable);

    arpr_clock_gen #(
        .HALF_CYCLES(HALF_CYCLES),
        .BCLKS_PER_HALF(BCLKS_PER_HALF)
    ) u_clock_gen (
        .clk(clk),
        .rst(rst),
        .run(clk_run),
        .bclk_invert(aif_reg.bclk_invert),
        .frame_invert(frame_invert),
        .bclk_o(gen_bclk),
        .lrclk_o(gen_lrclk),
        .clocks_oe(gen_oe)
    );

    // Pin drive; in slave mode both clocks are inputs
    always_ff @(posedge clk) begin
        if (rst) begin
            bclk_o <= 1'b0;
            lrclk_o <= 1'b0;
            bclk_oe <= 1'b0;
            lrclk_oe <= 1'b0;
        end else begin
            bclk_o <= gen_bclk;
            lrclk_o <= gen_lrclk;
            bclk_oe <= gen_oe && aif_reg.interface_master_select;
            lrclk_oe <= gen_oe && aif_reg.interface_master_select;
        end
    end

    // Partner-driven clocks as seen by the receive formatter
    always_ff @(posedge clk) begin
        if (rst) begin
            slave_frame_clk <= 1'b0;
            slave_bit_clk <= 1'b0;
            dsp_mode_b <= 1'b0;
            rx_format <= ARPR_FMT_I2S;
        end else begin
            slave_frame_clk <= pin_stable_reg[2] ^ frame_invert;
            slave_bit_clk <= pin_stable_reg[1] ^ aif_reg.bclk_invert;
            dsp_mode_b <= aif_reg.rx_frame_polarity_dsp_variant
                && (aif_reg.rx_interface_format == ARPR_FMT_DSP);
            rx_format <= aif_reg.rx_interface_format;
        end
    end

    // Truncation mask from channel status word length
    logic [ARPR_WORD_W-1:0] keep_mask;
    logic [4:0] bits_clamped;
    always_comb begin
        bits_clamped = (rx_word_bits > 5'(ARPR_WORD_W))
            ? 5'(ARPR_WORD_W) : rx_word_bits;
        keep_mask = '1;
        if (!rb_reg.rx_truncation_mask) begin
            keep_mask = ~((ARPR_WORD_W)'({ARPR_WORD_W{1'b1}}
                >> bits_clamped));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_out_word <= '0;
            rx_out_valid <= 1'b0;
        end else begin
            rx_out_valid <= rx_word_valid;
            if (rx_word_valid) begin
                rx_out_word <= {
                    rx_flags & {ARPR_FLAG_W{rb_reg.flag_append_enable}},
                    rx_word & keep_mask};
            end
        end
    end

    // Power and rate controls out to the analogue and receiver blocks
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_high_rate_enable <= 1'b1;
            pll_power_down <= 1'b1;
            receiver_power_down <= 1'b1;
            transmitter_power_down <= 1'b1;
        end else begin
            rx_high_rate_enable <= rb_reg.rx_high_rate_enable;
            pll_power_down <= pwr_reg.pll_power_down;
            receiver_power_down <= pwr_reg.receiver_power_down;
            transmitter_power_down <= pwr_reg.transmitter_power_down;
        end
    end

endmodule : arpr_regs

// *** testbench/arpr_regs_properties.sv ***
`timescale 1ns/1ps
module arpr_regs_properties
    import arpr_pkg::*;
#(
    parameter int HALF_CYCLES = ARPR_BCLK_HALF_CYCLES,
    parameter int BCLKS_PER_HALF = ARPR_BCLKS_PER_HALF_FRAME
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire arpr_status_type status_in,
    input wire logic [7:0] status_readback,
    input wire logic status_readback_valid,
    input wire logic bclk_oe,
    input wire logic lrclk_oe,
    input wire logic dsp_mode_b,
    input wire logic [ARPR_WORD_W-1:0] rx_word,
    input wire logic [4:0] rx_word_bits,
    input wire logic [ARPR_FLAG_W-1:0] rx_flags,
    input wire logic rx_word_valid,
    input wire logic [ARPR_FLAG_W+ARPR_WORD_W-1:0] rx_out_word,
    input wire logic pll_power_down,
    input wire logic receiver_power_down,
    input wire logic transmitter_power_down
);
    logic [7:0] rb_reg;
    // Bit 1 is clock hold, bit 0 is master select
    logic [1:0] aif_reg;
    // Mode bits are not visible at the ports, so shadow them
    always_ff @(posedge clk) begin
        if (rst) begin
            rb_reg <= ARPR_READBACK_RESET;
        end else if (reg_write && reg_addr == ARPR_ADDR_READBACK) begin
            rb_reg <= reg_wdata & ARPR_READBACK_WMASK;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            aif_reg <= ARPR_RX_AIF_RESET[7:6];
        end else if (reg_write && reg_addr == ARPR_ADDR_RX_AIF) begin
            aif_reg <= reg_wdata[7:6];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_dsp_variant: assert property (
        reg_write && reg_addr == ARPR_ADDR_RX_AIF |-> ##2 dsp_mode_b ==
        ($past(reg_wdata[5], 2) && $past(reg_wdata[1:0], 2) == 2'h3))
        else $error("dsp variant output wrong after write");
    a_slave_quiet: assert property (
        !aif_reg[0] [*6] |-> !bclk_oe && !lrclk_oe)
        else $error("clock pins driven in slave mode");
    a_master_hold: assert property (
        (aif_reg[1] && aif_reg[0]) [*8] |-> bclk_oe && lrclk_oe)
        else $error("clocks not driven in master hold mode");
    a_select_int: assert property (
        reg_read && rb_reg[2:0] == ARPR_SEL_INT
        |=> status_readback == $past(status_in.int_status))
        else $error("interrupt status not returned");
    a_stream_valid: assert property (
        rb_reg[3] |=> status_readback_valid)
        else $error("continuous readback not valid");
    a_flag_append: assert property (
        rx_word_valid |=> rx_out_word[27:24] ==
        ($past(rb_reg[4]) ? $past(rx_flags) : 4'h0))
        else $error("flag field wrong");
    a_no_truncate: assert property (
        rx_word_valid && (rb_reg[6] || rx_word_bits >= 5'h18)
        |=> rx_out_word[23:0] == $past(rx_word))
        else $error("word altered without truncation");
    a_power_copy: assert property (
        reg_write && reg_addr == ARPR_ADDR_POWER |-> ##2
        {transmitter_power_down, receiver_power_down, pll_power_down}
        == $past(reg_wdata[2:0], 2))
        else $error("power-down outputs differ from written bits");
    c_stream: cover property (rb_reg[3] && status_readback_valid);
    c_master: cover property (bclk_oe && lrclk_oe);
    c_dsp_b: cover property (dsp_mode_b);
endmodule : arpr_regs_properties

bind arpr_regs arpr_regs_properties #(.HALF_CYCLES(HALF_CYCLES),
    .BCLKS_PER_HALF(BCLKS_PER_HALF)) arpr_regs_properties_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .status_in(status_in),
    .status_readback(status_readback),
    .status_readback_valid(status_readback_valid), .bclk_oe(bclk_oe),
    .lrclk_oe(lrclk_oe), .dsp_mode_b(dsp_mode_b), .rx_word(rx_word),
    .rx_word_bits(rx_word_bits), .rx_flags(rx_flags),
    .rx_word_valid(rx_word_valid), .rx_out_word(rx_out_word),
    .pll_power_down(pll_power_down),
    .receiver_power_down(receiver_power_down),
    .transmitter_power_down(transmitter_power_down));

// *** testbench/arpr_audio_partner.sv ***
`timescale 1ns/1ps
module arpr_audio_partner (
    input wire logic clk,
    input wire logic en,
    output logic bclk,
    output logic lrclk
);
    logic [8:0] cnt_reg = 9'h000;
    logic released_reg = 1'b1;
    initial bclk = 1'b0;
    initial lrclk = 1'b0;
    // Bit clock 8 cycles, frame clock toggles every 32 bit clocks
    always @(posedge clk) begin
        if (en) begin
            released_reg <= 1'b0;
            cnt_reg <= cnt_reg + 9'h001;
            bclk <= cnt_reg[2];
            lrclk <= cnt_reg[8];
        end else if (!released_reg) begin
            // No pull: show the inverse once, then stand still
            released_reg <= 1'b1;
            cnt_reg <= 9'h000;
            bclk <= ~bclk;
            lrclk <= ~lrclk;
        end
    end
endmodule : arpr_audio_partner

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import arpr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, status_readback;
    logic reg_rdata_valid, status_readback_valid, bclk_oe, lrclk_oe;
    logic spdif_lock_pin = 1'b0, partner_en = 1'b0, bclk_i, lrclk_i;
    logic slave_frame_clk, dsp_mode_b, rx_word_valid = 1'b0, rx_out_valid;
    logic rx_high_rate_enable, pll_power_down, receiver_power_down;
    logic transmitter_power_down;
    logic bclk_o, lrclk_o, slave_bit_clk, bclk_seen;
    logic [23:0] rx_word = 24'h000000;
    logic [4:0] rx_word_bits = 5'h00;
    logic [3:0] rx_flags = 4'h0;
    logic [27:0] rx_out_word;
    arpr_status_type status_in;
    arpr_format_type rx_format;
    int error_cnt = 0, n_checks = 0;
    always #4 clk = ~clk;
    arpr_audio_partner arpr_audio_partner_i (.clk(clk), .en(partner_en),
        .bclk(bclk_i), .lrclk(lrclk_i));
    arpr_regs arpr_regs_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .status_in(status_in), .status_readback(status_readback),
        .status_readback_valid(status_readback_valid),
        .spdif_lock_pin(spdif_lock_pin), .bclk_i(bclk_i), .lrclk_i(lrclk_i),
        .bclk_o(bclk_o), .bclk_oe(bclk_oe), .lrclk_o(lrclk_o),
        .lrclk_oe(lrclk_oe), .slave_frame_clk(slave_frame_clk),
        .slave_bit_clk(slave_bit_clk),
        .dsp_mode_b(dsp_mode_b), .rx_format(rx_format), .rx_word(rx_word),
        .rx_word_bits(rx_word_bits), .rx_flags(rx_flags),
        .rx_word_valid(rx_word_valid), .rx_out_word(rx_out_word),
        .rx_out_valid(rx_out_valid), .rx_high_rate_enable(rx_high_rate_enable),
        .pll_power_down(pll_power_down),
        .receiver_power_down(receiver_power_down),
        .transmitter_power_down(transmitter_power_down));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(logic [6:0] a, logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk("rdata_valid", 1, reg_rdata_valid);
        chk("rdata", e, reg_rdata);
    endtask : rd
    task automatic word(logic [23:0] w, logic [4:0] b, logic [27:0] e);
        @(posedge clk);
        rx_word <= w;
        rx_word_bits <= b;
        rx_flags <= 4'hA;
        rx_word_valid <= 1'b1;
        @(posedge clk);
        rx_word_valid <= 1'b0;
        #1;
        chk("out_valid", 1, rx_out_valid);
        chk("out_word", e, rx_out_word);
    endtask : word
    function automatic logic [7:0] sel_exp(int i);
        case (i)
            0: return 8'hA0;
            6: return 8'hC6;
            7: return 8'h00;
            default: return 8'hB0 + 8'(i);
        endcase
    endfunction : sel_exp
    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        #(8 * 50000);
        error_cnt++;
        summarize();
    end
    initial begin
        status_in <= {8'hA0, 8'hB5, 8'hB4, 8'hB3, 8'hB2, 8'hB1, 8'hC6};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(ARPR_ADDR_RX_AIF, 8'h06);
        rd(ARPR_ADDR_READBACK, 8'h80);
        rd(ARPR_ADDR_POWER, 8'h07);
        chk("high_rate", 1, rx_high_rate_enable);
        chk("format", 2, rx_format);
        wr(7'h1F, 8'h55);
        rd(7'h1F, 8'h00);
        wr(ARPR_ADDR_READBACK, 8'hFF);
        rd(ARPR_ADDR_READBACK, 8'hDF);
        wr(ARPR_ADDR_POWER, 8'hFF);
        rd(ARPR_ADDR_POWER, 8'h07);
        for (int i = 0; i < 8; i++) begin
            wr(ARPR_ADDR_POWER, 8'(i));
            settle(3);
            chk("pd", i, {transmitter_power_down, receiver_power_down,
                pll_power_down});
        end
        for (int i = 0; i < 8; i++) begin
            wr(ARPR_ADDR_READBACK, 8'h80 | 8'(i));
            rd(ARPR_ADDR_READBACK, 8'h80 | 8'(i));
            chk("status", sel_exp(i), status_readback);
            chk("st_valid", 1, status_readback_valid);
            settle(1);
            chk("st_idle", 0, status_readback_valid);
        end
        wr(ARPR_ADDR_READBACK, 8'h09);
        settle(4);
        chk("stream", 9'h1B1, {status_readback_valid, status_readback});
        @(posedge clk);
        status_in.chan_status[0] <= 8'h5A;
        settle(3);
        chk("stream_upd", 8'h5A, status_readback);
        wr(ARPR_ADDR_READBACK, 8'h00);
        settle(3);
        chk("stream_off", 0, status_readback_valid);
        chk("high_rate", 0, rx_high_rate_enable);
        word(24'hFFFFFF, 5'h10, 28'h0FFFF00);
        word(24'hFFFFFF, 5'h00, 28'h0000000);
        word(24'h123456, 5'h1F, 28'h0123456);
        wr(ARPR_ADDR_READBACK, 8'h10);
        word(24'hFFFFFF, 5'h0C, 28'hAFFF000);
        wr(ARPR_ADDR_READBACK, 8'h40);
        word(24'h123456, 5'h08, 28'h0123456);
        for (int i = 0; i < 4; i++) begin
            wr(ARPR_ADDR_RX_AIF, 8'h20 | 8'(i));
            settle(3);
            chk("format", i, rx_format);
            chk("dsp_b", i == 3, dsp_mode_b);
        end
        partner_en <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            wr(ARPR_ADDR_RX_AIF, p ? 8'h22 : 8'h02);
            @(posedge lrclk_i);
            settle(12);
            chk("frame", lrclk_i ^ p[0], slave_frame_clk);
            chk("slave_oe", 0, {bclk_oe, lrclk_oe});
        end
        partner_en <= 1'b0;
        wr(ARPR_ADDR_RX_AIF, 8'hC2);
        settle(10);
        chk("oe_hold", 2'h3, {bclk_oe, lrclk_oe});
        chk("lrclk_start", 0, lrclk_o);
        chk("bit_clk_in", bclk_i, slave_bit_clk);
        bclk_seen = bclk_o;
        settle(ARPR_BCLK_HALF_CYCLES);
        chk("bclk_toggle", !bclk_seen, bclk_o);
        wr(ARPR_ADDR_RX_AIF, 8'h42);
        settle(16);
        chk("oe_lost", 2'h0, {bclk_oe, lrclk_oe});
        chk("bclk_stop", 0, bclk_o);
        wr(ARPR_ADDR_POWER, 8'h00);
        spdif_lock_pin <= 1'b1;
        settle(16);
        chk("oe_lock", 2'h3, {bclk_oe, lrclk_oe});
        @(posedge clk);
        spdif_lock_pin <= 1'b0;
        settle(16);
        chk("oe_unlock", 2'h0, {bclk_oe, lrclk_oe});
        summarize();
    end
endmodule : testbench
